/* hdl/cee_event_unit.sv */
// Event entry and return sequencer: masks, prioritises and vectors events,
// and drives stack push/pop requests for the core's load/store path.
// Assumes the pipeline supplies per-stage event vectors and a stack port that
// answers each word with a one-cycle i_stack_done.
`timescale 1ns/1ps

// How it works
// [RULE1] Pending events are refused while their status word mask bit is set.
// [RULE2] NMI, unrecoverable, multiple hit and bus errors ignore all masks.
// [RULE3] Accepting an event sets masks of all equal or lower priority sources; scall sets none, interrupt and debug entry leave exception mask clear.
// [RULE4] Sources hold requests until accepted; nothing is latched here.
// [RULE5] Non-scall, non-debug entry pushes status word and PC to system stack.
// [RULE6] Interrupt levels 0..3 also push registers 8..12 and link register.
// [RULE7] Exceptions set both exception mask and global mask.
// [RULE8] Entry sets mode, selects bank and loads handler address into PC.
// [RULE9] Event return pops status and PC, plus r8..r12 and link for interrupts.
// [RULE10] Supervisor call and its return save/restore PC and status via stack.
// [RULE11] Debug request enters debug mode unless debug entry mask set.
// [RULE12] Debug entry sets debug flag and branches to debug handler.
// [RULE13] Debug saves context in dedicated return registers, not the stack.
// [RULE14] Debug return leaves debug mode restoring dedicated registers.
// [RULE15] Reset wins everything and fetches from the fixed boot address.
// [RULE16] Interrupt controller gives a 14-bit autovector offset from vector base.
// [RULE17] Protection faults map to protection, miss or multiple-hit exceptions.
// [RULE18] Oldest instruction's events first; fixed priority within one.
// [RULE19] Scall and protection misses use wide dedicated handler offsets.
// [RULE20] Other exceptions use distinct 4-byte-step offsets from vector base.
// [RULE21] Data and instruction bus errors are separate, saving non-completed PC.
// [RULE22] Faults save faulting PC, interrupts next PC, scall PC plus two.
// [RULE23] Handler address is vector base OR offset, never a sum.
// [RULE24] After reset the core is in supervisor mode.
// [RULE25] Events evaluated each cycle; entry runs as one indivisible sequence.
module cee_event_unit
	import cee_pkg::*;
#(
	parameter int unsigned STAGES = 3
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Events per pipeline stage, stage 0 oldest
	input wire logic [EV_COUNT-1:0] i_stage_events [STAGES],
	input wire logic [31:0] i_stage_pc [STAGES],
	input wire logic [31:0] i_next_pc,
	input wire logic i_boundary,
	// Interrupt controller and debug unit
	input wire logic [13:0] i_autovector,
	input wire logic [31:0] i_debug_handler,
	// Return instructions and software status writes
	input wire logic i_ret_event,
	input wire logic i_ret_scall,
	input wire logic i_ret_debug,
	input wire logic i_status_wr,
	input wire logic [31:0] i_status_wdata,
	input wire logic [31:0] i_vector_base,
	// Stack port: pop data and completion
	input wire logic i_stack_done,
	input wire logic [31:0] i_stack_rdata,
	// Outputs
	output logic [31:0] o_status_word,
	output logic [31:0] o_pc,
	output logic o_pc_load,
	output logic o_busy,
	output logic o_stack_req,
	output logic o_stack_push,
	output logic [2:0] o_stack_item,
	output logic [31:0] o_stack_wdata,
	output logic [STAGES-1:0] o_flush,
	output logic [2:0] o_bank,
	output cee_ctx_s o_debug_ret
);

	// Stage count must fit the flush mask and the selection loop
	if (STAGES < 1 || STAGES > 8) begin : g_bad_stages
		$error("STAGES out of range");
	end

	// ************************************************************
	// Sequencer state
	// ************************************************************
	typedef enum logic [2:0] {CEE_IDLE, CEE_PUSH, CEE_POP, CEE_BRANCH} cee_state_e;
	cee_state_e state_q;
	logic [31:0] status_q;
	logic [31:0] pc_q;
	logic pc_load_q;
	logic [2:0] item_q;
	logic [2:0] last_item_q;
	logic [31:0] target_q;
	logic [31:0] new_status_q;
	logic [31:0] saved_pc_q;
	logic [31:0] saved_status_q;
	cee_ctx_s debug_ret_q;
	logic [STAGES-1:0] flush_q;

	// Mask bit for an event number; critical events return zero
	function automatic logic ev_masked(input int unsigned ev, input logic [31:0] sw);
		if (ev == EV_DEBUG)
			return sw[SW_DEBUG_ENTRY_MASK]; // [RULE11]
		if (ev <= EV_NMI)
			return 1'b0; // [RULE2]
		if (ev >= EV_IRQ_LEVEL_THREE && ev <= EV_IRQ_LEVEL_ZERO)
			return sw[SW_IRQ_LEVEL3_MASK - (ev - EV_IRQ_LEVEL_THREE)] | sw[SW_GLOBAL_IRQ_MASK];
		return sw[SW_EXCEPTION_MASK]; // [RULE1]
	endfunction

	function automatic logic is_irq(input int unsigned ev);
		return ev >= EV_IRQ_LEVEL_THREE && ev <= EV_IRQ_LEVEL_ZERO;
	endfunction

	// ************************************************************
	// Selection: oldest stage with an unmasked event, then priority
	// ************************************************************
	logic sel_valid;
	int unsigned sel_ev;
	int unsigned sel_stage;
	always_comb begin
		sel_valid = 1'b0;
		sel_ev = 0;
		sel_stage = 0;
		// Younger stages are ignored once an older one has an unmasked event [RULE18]
		for (int s = STAGES - 1; s >= 0; s--) begin
			for (int e = EV_COUNT - 1; e >= 0; e--) begin
				if (i_stage_events[s][e] && !ev_masked(e, status_q)) begin // [RULE1]
					sel_valid = 1'b1;
					sel_ev = e;
					sel_stage = s;
				end
			end
		end
	end

	// Entry decision: taken only at a boundary while idle [RULE25]
	logic accept;
	assign accept = sel_valid && i_boundary && state_q == CEE_IDLE;

	// Handler address: OR, so vector base must be aligned [RULE23]
	logic [31:0] handler;
	always_comb begin
		if (sel_ev == EV_DEBUG)
			handler = i_debug_handler; // [RULE12]
		else if (is_irq(sel_ev))
			handler = i_vector_base | {18'h0_0000, i_autovector}; // [RULE16]
		else
			handler = i_vector_base | {18'h0_0000, EV_OFFSET[sel_ev]}; // [RULE17] [RULE19] [RULE20]
	end

	// Return address selection [RULE22] [RULE21]
	logic [31:0] ret_pc;
	always_comb begin
		if (sel_ev == EV_SCALL)
			ret_pc = i_stage_pc[sel_stage] + SCALL_PC_STEP;
		else if (sel_ev <= EV_MULTIHIT && sel_ev != EV_DEBUG || sel_ev > EV_NMI && !is_irq(sel_ev)
			&& sel_ev != 13)
			ret_pc = i_stage_pc[sel_stage];
		else
			ret_pc = i_next_pc; // First non-completed instruction
	end

	// New status word: masks of equal or lower priority, mode, debug flag
	logic [31:0] entry_status;
	logic [2:0] entry_mode;
	always_comb begin
		entry_status = status_q;
		entry_mode = MODE_EXCEPTION;
		if (sel_ev == EV_DEBUG) begin
			entry_status[SW_DEBUG_ACTIVE_FLAG] = 1'b1; // [RULE12]
			entry_status[SW_IRQ_LEVEL3_MASK:SW_GLOBAL_IRQ_MASK] = 5'h1f;
		end else if (sel_ev == EV_SCALL) begin
			entry_mode = MODE_SUPERVISOR;
		end else if (is_irq(sel_ev)) begin
			entry_mode = MODE_IRQ_LEVEL_THREE - 3'(sel_ev - EV_IRQ_LEVEL_THREE);
			// Own level and all below it [RULE3]
			for (int l = 0; l < 4; l++)
				if (l <= 3 - (sel_ev - EV_IRQ_LEVEL_THREE))
					entry_status[SW_IRQ_LEVEL0_MASK + l] = 1'b1;
		end else begin
			if (sel_ev == EV_NMI)
				entry_mode = MODE_NMI;
			// Exceptions rank above nothing maskable below them [RULE7] [RULE3]
			entry_status[SW_EXCEPTION_MASK] = 1'b1;
			entry_status[SW_GLOBAL_IRQ_MASK] = 1'b1;
			if (sel_ev <= EV_NMI)
				entry_status[SW_IRQ_LEVEL3_MASK:SW_IRQ_LEVEL0_MASK] = 4'hf;
		end
		// Debug runs in exception context too, so every entry rewrites the mode [RULE13]
		entry_status[SW_MODE_LSB +: 3] = entry_mode; // [RULE8]
	end

	// ************************************************************
	// Sequencer: push, pop and branch as one uninterrupted run
	// ************************************************************
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			state_q <= CEE_IDLE;
			item_q <= 3'h0;
			last_item_q <= 3'h0;
			target_q <= 32'h0000_0000;
			new_status_q <= 32'h0000_0000;
			saved_pc_q <= 32'h0000_0000;
			saved_status_q <= 32'h0000_0000;
		end else begin
			case (state_q)
				CEE_IDLE: begin
					item_q <= 3'h0;
					if (accept) begin
						target_q <= handler;
						new_status_q <= entry_status;
						saved_pc_q <= ret_pc;
						saved_status_q <= status_q;
						// Eight words for interrupts, two otherwise [RULE5] [RULE6] [RULE10]
						last_item_q <= is_irq(sel_ev) ? 3'h7 : 3'h1;
						// Debug skips the stack [RULE13]
						state_q <= (sel_ev == EV_DEBUG) ? CEE_BRANCH : CEE_PUSH;
					end else if (i_ret_event || i_ret_scall) begin
						// Interrupt modes also restore r8..r12 and link [RULE9]
						last_item_q <= (status_q[SW_MODE_LSB +: 3] >= MODE_IRQ_LEVEL_ZERO &&
							status_q[SW_MODE_LSB +: 3] <= MODE_IRQ_LEVEL_THREE && i_ret_event) ? 3'h7 : 3'h1;
						state_q <= CEE_POP;
					end
				end
				CEE_PUSH: begin
					if (i_stack_done) begin
						item_q <= item_q + 3'h1;
						if (item_q == last_item_q)
							state_q <= CEE_BRANCH;
					end
				end
				CEE_POP: begin
					if (i_stack_done) begin
						item_q <= item_q + 3'h1;
						if (item_q == 3'h0)
							new_status_q <= i_stack_rdata;
						if (item_q == 3'h1)
							target_q <= i_stack_rdata;
						if (item_q == last_item_q)
							state_q <= CEE_BRANCH;
					end
				end
				CEE_BRANCH: state_q <= CEE_IDLE;
				default: state_q <= CEE_IDLE;
			endcase
		end
	end

	// Status word and PC: reset enters supervisor at boot address [RULE15] [RULE24]
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			status_q <= RESET_STATUS;
			pc_q <= RESET_PC;
			pc_load_q <= 1'b1;
		end else begin
			pc_load_q <= 1'b0;
			if (state_q == CEE_BRANCH) begin
				status_q <= new_status_q; // [RULE8] [RULE9]
				pc_q <= target_q;
				pc_load_q <= 1'b1;
			end else if (state_q == CEE_IDLE && !accept && i_ret_debug) begin
				status_q <= debug_ret_q.status; // [RULE14]
				pc_q <= debug_ret_q.pc;
				pc_load_q <= 1'b1;
			end else if (state_q == CEE_IDLE && i_status_wr) begin
				status_q <= i_status_wdata; // Mode bits writable in debug [RULE13]
			end
		end
	end

	// Dedicated debug return context [RULE13]
	always_ff @(posedge i_clock) begin
		if (!i_rst_b)
			debug_ret_q <= '0;
		else if (accept && sel_ev == EV_DEBUG)
			debug_ret_q <= '{status: status_q, pc: ret_pc};
	end

	// Flush the accepted stage and all younger ones
	always_ff @(posedge i_clock) begin
		if (!i_rst_b)
			flush_q <= '0;
		else
			flush_q <= accept ? ~((STAGES)'((1 << sel_stage) - 1)) : '0; // [RULE18]
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_status_word = status_q;
	assign o_pc = pc_q;
	assign o_pc_load = pc_load_q;
	assign o_busy = state_q != CEE_IDLE;
	assign o_stack_req = state_q == CEE_PUSH || state_q == CEE_POP;
	assign o_stack_push = state_q == CEE_PUSH;
	assign o_stack_item = item_q;
	// Word 0 status, 1 PC, 2..7 registers (bank supplies them)
	assign o_stack_wdata = (item_q == 3'h0) ? saved_status_q : saved_pc_q;
	assign o_flush = flush_q;
	assign o_bank = status_q[SW_MODE_LSB +: 3];
	assign o_debug_ret = debug_ret_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	a_reset_boot: assert property (@(posedge i_clock) // [RULE15]
		!i_rst_b |=> o_pc == RESET_PC && o_pc_load
		&& o_status_word[SW_MODE_LSB +: 3] == MODE_SUPERVISOR)
		else $error("Reset did not load boot address in supervisor");
	a_debug_flag: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE12]
		accept && sel_ev == EV_DEBUG |=> ##1 status_q[SW_DEBUG_ACTIVE_FLAG])
		else $error("Debug flag not set");
	a_debug_no_stack: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE13]
		accept && sel_ev == EV_DEBUG |=> !o_stack_req ##1 !o_stack_req)
		else $error("Debug entry used stack");
	a_exc_masks: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE7]
		accept && sel_ev > EV_IRQ_LEVEL_ZERO && sel_ev != EV_SCALL |=> new_status_q[SW_EXCEPTION_MASK]
		&& new_status_q[SW_GLOBAL_IRQ_MASK])
		else $error("Exception masks not set");
	a_push_status: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE5]
		accept && sel_ev != EV_DEBUG |=> o_stack_push && o_stack_item == 3'h0
		&& o_stack_wdata == $past(status_q))
		else $error("Status not pushed first");
	a_or_vector: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE16]
		accept && is_irq(sel_ev) |=> target_q == ($past(i_vector_base)
		| {18'h0_0000, $past(i_autovector)}))
		else $error("Autovector target wrong");
	a_scall_ret: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE22]
		accept && sel_ev == EV_SCALL |=> saved_pc_q == $past(i_stage_pc[sel_stage]) + 32'h2)
		else $error("Scall return address wrong");
	// Mask checks read the status bits directly, not through the selection function
	a_masked_refused: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE1]
		accept && sel_ev > EV_IRQ_LEVEL_ZERO |-> !status_q[SW_EXCEPTION_MASK])
		else $error("Masked exception accepted");
	a_irq_gated: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE1]
		accept && is_irq(sel_ev) |-> !status_q[SW_GLOBAL_IRQ_MASK])
		else $error("Interrupt accepted under global mask");
	a_critical_taken: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE2]
		i_stage_events[0][EV_NMI] && i_boundary && state_q == CEE_IDLE |-> accept)
		else $error("Unmaskable event refused");
	c_irq_entry: cover property (@(posedge i_clock) accept && is_irq(sel_ev));
	c_scall_entry: cover property (@(posedge i_clock) accept && sel_ev == EV_SCALL);
	c_debug_entry: cover property (@(posedge i_clock) accept && sel_ev == EV_DEBUG);
	c_event_return: cover property (@(posedge i_clock) state_q == CEE_POP && i_stack_done);

endmodule // cee_event_unit

/* hdl/cee_pkg.sv */
// Package for the core event entry and return unit: status word layout,
// event codes, handler offsets and reset constants.
// Assumes a 32-bit core with one clock and a synchronous active-low reset.
package cee_pkg;

	// ************************************************************
	// Status word field positions
	// ************************************************************
	localparam int unsigned SW_GLOBAL_IRQ_MASK = 16;
	localparam int unsigned SW_IRQ_LEVEL0_MASK = 17;
	localparam int unsigned SW_IRQ_LEVEL1_MASK = 18;
	localparam int unsigned SW_IRQ_LEVEL2_MASK = 19;
	localparam int unsigned SW_IRQ_LEVEL3_MASK = 20;
	localparam int unsigned SW_EXCEPTION_MASK = 21;
	localparam int unsigned SW_MODE_LSB = 22;
	localparam int unsigned SW_DEBUG_ENTRY_MASK = 26;
	localparam int unsigned SW_DEBUG_ACTIVE_FLAG = 27;

	// ************************************************************
	// Modes, reset values and fixed addresses
	// ************************************************************
	localparam logic [2:0] MODE_APPLICATION = 3'h0;
	localparam logic [2:0] MODE_SUPERVISOR = 3'h1;
	localparam logic [2:0] MODE_IRQ_LEVEL_ZERO = 3'h2;
	localparam logic [2:0] MODE_INT1 = 3'h3;
	localparam logic [2:0] MODE_INT2 = 3'h4;
	localparam logic [2:0] MODE_IRQ_LEVEL_THREE = 3'h5;
	localparam logic [2:0] MODE_EXCEPTION = 3'h6;
	localparam logic [2:0] MODE_NMI = 3'h7;
	localparam logic [31:0] RESET_PC = 32'h8000_0000;
	localparam logic [31:0] RESET_STATUS = 32'h0060_0000; // Supervisor, exceptions masked
	localparam logic [31:0] SCALL_PC_STEP = 32'h0000_0002;

	// ************************************************************
	// Event numbers in priority order (index 0 is highest)
	// ************************************************************
	localparam int unsigned EV_COUNT = 27;
	localparam int unsigned EV_DEBUG = 0;
	localparam int unsigned EV_UNRECOV = 1;
	localparam int unsigned EV_MULTIHIT = 2;
	localparam int unsigned EV_BUSERR_DATA = 3;
	localparam int unsigned EV_BUSERR_INSTR = 4;
	localparam int unsigned EV_NMI = 5;
	localparam int unsigned EV_IRQ_LEVEL_THREE = 6;
	localparam int unsigned EV_IRQ_LEVEL_ZERO = 9;
	localparam int unsigned EV_INSTR_MISS = 11;
	localparam int unsigned EV_SCALL = 19;
	localparam int unsigned EV_DATA_MISS_RD = 22;

	// Handler offsets, indexed by event number (autovector slots unused)
	localparam logic [13:0] EV_OFFSET [EV_COUNT] = '{
		14'h0000, 14'h0000, 14'h0004, 14'h0008, 14'h000c, 14'h0010,
		14'h0000, 14'h0000, 14'h0000, 14'h0000,
		14'h0014, 14'h0050, 14'h0018, 14'h001c, 14'h0020, 14'h0024,
		14'h0028, 14'h002c, 14'h0030, 14'h0100, 14'h0034, 14'h0038,
		14'h0060, 14'h0070, 14'h003c, 14'h0040, 14'h0044};

	// Context captured or restored as one unit
	typedef struct packed {
		logic [31:0] status;
		logic [31:0] pc;
	} cee_ctx_s;

endpackage : cee_pkg

/* test/cee_partner.sv */
// Far-side model: interrupt controller, debug unit and system stack memory.
// Assumes the unit holds its stack request until the last word is done.
`timescale 1ns/1ps
module cee_partner
	import cee_pkg::*;
#(
	parameter logic [13:0] AV_BASE = 14'h0200,
	parameter logic [31:0] DBG_HANDLER = 32'h0000_0f00
) (
	// Clock and bench controls
	input wire logic i_clock,
	input wire logic i_slow,
	input wire logic [5:0] i_line,
	// Stack port from the unit
	input wire logic i_req,
	input wire logic i_push,
	input wire logic [2:0] i_item,
	input wire logic [31:0] i_wdata,
	// Answers
	output logic o_done,
	output logic [31:0] o_rdata,
	output logic [13:0] o_autovector,
	output logic [31:0] o_debug_handler
);
	// ************************************************************
	// Vectors and stack words
	// ************************************************************
	logic [31:0] mem [8];
	logic [1:0] wait_q;

	// Each line gets its own 4-byte slot inside the 14-bit range
	assign o_autovector = AV_BASE | {6'h00, i_line, 2'h0};
	assign o_debug_handler = DBG_HANDLER;

	initial begin
		o_done = 1'b0;
		o_rdata = 32'h0;
		wait_q = 2'h0;
	end

	// One word per done; data inverts on each idle cycle, so a stale value matches again every second idle cycle
	always @(posedge i_clock) begin
		o_done <= 1'b0;
		if (i_req && !o_done) begin
			if (wait_q == (i_slow ? 2'h3 : 2'h0)) begin
				o_done <= 1'b1;
				wait_q <= 2'h0;
				if (i_push)
					mem[i_item] <= i_wdata;
				else
					o_rdata <= mem[i_item];
			end else begin
				wait_q <= wait_q + 2'h1;
			end
		end else if (!o_done) begin
			o_rdata <= ~o_rdata;
		end
	end
endmodule // cee_partner

/* test/cee_event_unit_bench.sv */
// Self-checking bench for the event entry and return unit.
// Assumes the partner model answers the stack port and supplies vectors.
`timescale 1ns/1ps
module cee_event_unit_bench
	import cee_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic [EV_COUNT-1:0] ev [3];
	logic [31:0] spc [3];
	logic [31:0] npc, vb, sw_d, st, pc, wdata, rdata, dbg, base;
	logic sw_wr, r_ev, r_sc, r_db, slow, load, busy, req, push, done;
	logic [5:0] line;
	logic [13:0] av;
	logic [2:0] item, bank, flush;
	cee_ctx_s dret;
	logic bnd = 1'b1;
	logic [2:0] fl_seen = 3'h0;
	int mismatches = 0;
	int n_checks = 0;
	int pushes = 0;

	always #5 i_clock = ~i_clock;
	// Words pushed, to tell a short context save from a full one
	always @(posedge i_clock) if (done && push) pushes++;
	// Last flush mask the unit raised
	always @(posedge i_clock) if (|flush) fl_seen = flush;

	cee_event_unit #(.STAGES(3)) dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_stage_events(ev), .i_stage_pc(spc), .i_next_pc(npc), .i_boundary(bnd),
		.i_autovector(av), .i_debug_handler(dbg), .i_ret_event(r_ev),
		.i_ret_scall(r_sc), .i_ret_debug(r_db), .i_status_wr(sw_wr),
		.i_status_wdata(sw_d), .i_vector_base(vb), .i_stack_done(done),
		.i_stack_rdata(rdata), .o_status_word(st), .o_pc(pc), .o_pc_load(load),
		.o_busy(busy), .o_stack_req(req), .o_stack_push(push), .o_stack_item(item),
		.o_stack_wdata(wdata), .o_flush(flush), .o_bank(bank), .o_debug_ret(dret));
	cee_partner pm (.i_clock(i_clock), .i_slow(slow), .i_line(line), .i_req(req),
		.i_push(push), .i_item(item), .i_wdata(wdata), .o_done(done), .o_rdata(rdata),
		.o_autovector(av), .o_debug_handler(dbg));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Expected return address: kind 0 faulting pc, 1 next pc, 2 scall pc plus two
	function automatic logic [31:0] exp_ret(input int k, input logic [31:0] f,
		input logic [31:0] n);
		return (k == 1) ? n : f + ((k == 2) ? 32'h2 : 32'h0);
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Bounded wait for the handler branch
	task automatic wait_load();
		int n;
		n = 0;
		while (load !== 1'b1 && n < 60) begin
			@(negedge i_clock);
			n++;
		end
		check("pc_load", 32'h1, {31'h0, load});
	endtask

	task automatic wr(input logic [31:0] s);
		sw_wr = 1'b1;
		sw_d = s;
		@(negedge i_clock);
		sw_wr = 1'b0;
	endtask

	// Request stays up until the unit goes busy, then drops
	task automatic fire(input int b, input logic [EV_COUNT-1:0] young);
		int n;
		n = 0;
		ev[0][b] = 1'b1;
		ev[1] = young;
		// Off an instruction boundary nothing may be taken
		bnd = 1'b0;
		repeat (2) @(negedge i_clock);
		check("no boundary", 32'h0, {31'h0, busy});
		bnd = 1'b1;
		while (busy !== 1'b1 && n < 20) begin
			@(negedge i_clock);
			n++;
		end
		ev[0] = '0;
		ev[1] = '0;
		wait_load();
	endtask

	task automatic ret(input int k);
		r_ev = (k == 0);
		r_sc = (k == 1);
		r_db = (k == 2);
		@(negedge i_clock);
		{r_ev, r_sc, r_db} = 3'h0;
		wait_load();
	endtask

	task automatic blocked(input logic [31:0] s, input int b);
		wr(s);
		ev[0][b] = 1'b1;
		repeat (8) @(negedge i_clock);
		check("busy", 32'h0, {31'h0, busy});
		ev[0] = '0;
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (20000) @(posedge i_clock);
		mismatches++;
		close_out();
	end

	initial begin
		int bits [10] = '{1, 2, 3, 4, 11, 13, 16, 19, 22, 26};
		int offs [10] = '{'h00, 'h04, 'h08, 'h0c, 'h50, 'h1c, 'h28, 'h100, 'h60, 'h44};
		int kind [10] = '{0, 0, 1, 1, 0, 1, 0, 2, 0, 0};
		int mb [5] = '{9, 9, 14, 0, 6};
		logic [31:0] ms [5] = '{32'h0042_0000, 32'h0041_0000, 32'h0060_0000,
			32'h0440_0000, 32'h0050_0000};
		logic [31:0] ra;
		int p0;
		void'($urandom(95));
		for (int s = 0; s < 3; s++) begin
			ev[s] = '0;
			spc[s] = $urandom & 32'hffff_fffe;
		end
		{sw_wr, r_ev, r_sc, r_db, slow} = 5'h0;
		sw_d = 32'h0;
		base = 32'h0040_0000; // Supervisor, every mask clear
		vb = $urandom;
		npc = $urandom & 32'hffff_fffe;
		line = 6'($urandom);
		repeat (20) @(negedge i_clock);
		check("reset pc", 32'h8000_0000, pc);
		check("reset status", 32'h0060_0000, st);
		i_rst_b = 1'b1;
		@(negedge i_clock);
		// Global, level 0, level 3, exception and debug entry mask bits, each against an event it covers
		for (int i = 0; i < 5; i++) blocked(ms[i], mb[i]);
		// NMI gets through every mask, short stack frame
		wr(32'h047f_0000);
		p0 = pushes;
		fire(5, '0);
		check("nmi pc", vb | 32'h10, pc);
		check("nmi mode", 32'h7, {29'h0, st[24:22]});
		check("nmi bank", 32'h7, {29'h0, bank});
		check("nmi pushes", 32'h2, 32'(pushes - p0));
		check("saved status", 32'h047f_0000, pm.mem[0]);
		check("saved pc", npc, pm.mem[1]);
		ret(0);
		check("rete pc", npc, pc);
		check("rete status", 32'h047f_0000, st);
		// Interrupt level 0 with a slow stack: full frame
		slow = 1'b1;
		wr(base);
		p0 = pushes;
		fire(9, '0);
		check("int pc", vb | {18'h0, 14'h0200 | {6'h0, line, 2'h0}}, pc);
		check("int mode", 32'h2, {29'h0, st[24:22]});
		check("int pushes", 32'h8, 32'(pushes - p0));
		check("int masks", 32'h1, {30'h0, st[18:17]});
		ret(0);
		check("int rete pc", npc, pc);
		check("int rete status", base, st);
		slow = 1'b0;
		// Older illegal opcode wins over younger NMI
		wr(base);
		fire(14, 27'h20);
		check("age pc", vb | 32'h20, pc);
		check("age flush", 32'h7, {29'h0, fl_seen});
		check("age ret", spc[0], pm.mem[1]);
		check("exc masks", 32'h3, {30'h0, st[21], st[16]});
		ret(0);
		// Fixed offsets and return addresses across the table
		for (int i = 0; i < 10; i++) begin
			spc[0] = $urandom & 32'hffff_fffe;
			npc = $urandom & 32'hffff_fffe;
			ra = exp_ret(kind[i], spc[0], npc);
			wr(base);
			fire(bits[i], '0);
			check("handler", vb | 32'(offs[i]), pc);
			check("return addr", ra, pm.mem[1]);
			if (kind[i] != 2) check("exc mode", 32'h6, {29'h0, st[24:22]});
			ret((kind[i] == 2) ? 1 : 0);
			check("back pc", ra, pc);
		end
		// Debug entry keeps its context off the stack
		wr(base);
		p0 = pushes;
		fire(0, '0);
		check("dbg pc", 32'h0000_0f00, pc);
		check("dbg flag", 32'h1, {31'h0, st[27]});
		check("dbg mode", 32'h6, {29'h0, st[24:22]});
		check("dbg ret pc", npc, dret.pc);
		check("dbg ret status", base, dret.status);
		check("dbg pushes", 32'h0, 32'(pushes - p0));
		ret(2);
		check("retd pc", npc, pc);
		check("retd status", base, st);
		close_out();
	end
endmodule // cee_event_unit_bench
